/* File: src/wsc_pkg.sv */
/*
 * Package for the wake source configuration bank: register addresses,
 * reset values, write masks, bit positions, filter timing and carriers.
 * Assumes a 250 MHz core clock and a 16-bit serial configuration frame.
 */
package wsc_pkg;

   // ************************************************************
   // Register addresses (7-bit serial address field)
   // ************************************************************
   localparam logic [6:0] ADDR_TIMER_DOG_WAKE = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE       = 7'h07;
   localparam logic [6:0] ADDR_PIN_PULL       = 7'h08;
   localparam logic [6:0] ADDR_PIN_FILTER     = 7'h09;

   // ************************************************************
   // Reset values and writable bit masks
   // ************************************************************
   localparam logic [7:0] RST_TIMER_DOG_WAKE  = 8'h00;
   localparam logic [7:0] RST_EXT_WAKE        = 8'h07;
   localparam logic [7:0] RST_PIN_PULL        = 8'h00;
   localparam logic [7:0] RST_PIN_FILTER      = 8'h00;
   localparam logic [7:0] MASK_TIMER_DOG_WAKE = 8'hC4;
   localparam logic [7:0] MASK_EXT_WAKE       = 8'hA7;
   localparam logic [7:0] MASK_PIN_PULL       = 8'h3F;
   localparam logic [7:0] MASK_PIN_FILTER     = 8'h3F;
   // Fail-safe pattern: bits 7 and 5 kept, the rest forced
   localparam logic [7:0] FAILSAFE_KEEP_MASK  = 8'hA0;
   localparam logic [7:0] FAILSAFE_EXT_WAKE   = 8'h07;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_SECOND_TIMER_WAKE = 7;
   localparam int BIT_FIRST_TIMER_WAKE  = 6;
   localparam int BIT_DOG_STOP_UPPER    = 2;
   localparam int BIT_INT_GLOBAL        = 7;
   localparam int BIT_MEASURE_SELECT    = 5;
   localparam int FIELD_W               = 2;
   localparam int NUM_PINS              = 3;
   localparam int NUM_FLAGS             = 5;
   localparam int FLAG_FIRST_TIMER      = 3;
   localparam int FLAG_SECOND_TIMER     = 4;

   // ************************************************************
   // Codes of the pull and filter fields
   // ************************************************************
   localparam logic [1:0] PULL_NONE = 2'h0;
   localparam logic [1:0] PULL_DOWN = 2'h1;
   localparam logic [1:0] PULL_UP   = 2'h2;
   localparam logic [1:0] PULL_AUTO = 2'h3;
   localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
   localparam logic [1:0] FLT_STATIC_LONG  = 2'h1;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLOCK_MHZ        = 250;
   localparam int SHORT_FILTER_US  = 16;
   localparam int LONG_FILTER_US   = 64;
   localparam int CNT_W            = 15;
   localparam logic [CNT_W-1:0] SHORT_FILTER_CYC = CNT_W'(SHORT_FILTER_US * CLOCK_MHZ);
   localparam logic [CNT_W-1:0] LONG_FILTER_CYC  = CNT_W'(LONG_FILTER_US * CLOCK_MHZ);

   // ************************************************************
   // Serial frame
   // ************************************************************
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] ADDR_BITS  = 5'h08;
   localparam logic [4:0] FRAME_OVER = 5'h11;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic csn_n;
      logic sclk;
      logic sdi;
   } wsc_spi_in_s;

   typedef struct packed {
      logic sdo;
      logic sdo_oe;
   } wsc_spi_out_s;

endpackage : wsc_pkg

/* File: src/wsc_wake_cfg.sv */
/*
 * Wake source configuration bank with its serial slave, wake pin filters,
 * wake flags and interrupt request.
 * Assumes serial pins and wake pins are asynchronous, and that timer
 * events, fail-safe entry and watchdog updates come from same-clock logic.
 */
// Notes on behaviour
// - Second timer wakes the device only while internal wake bit 7 is set.
// - First timer cyclic wake only while internal wake bit 6 is set.
// - Reserved bits read zero; writes to them have no effect.
// - Internal wake bit 2: upper watchdog stop-mode disable; device may update it.
// - External wake bit 7: zero, only wakes interrupt; one, every status bit.
// - External wake bit 5 set disables first and second pin wake.
// - Measurement select runs measurement in normal mode; pin levels meaningless.
// - External wake bits 2,1,0 enable third, second, first wake pins.
// - Fail-safe entry forces the external wake register to its wakeable pattern, x kept.
// - Two-bit pull fields: none, pull-down, pull-up, automatic switching.
// - Filter code 00: static sensing, 16 us filter.
// - Filter code 01: static sensing, 64 us filter.
// - Filter code 10: cyclic sensing at first timer on-time end, 16 us.
// - Filter code 11: cyclic sensing at second timer on-time end, 16 us.
// - Lower watchdog stop-mode disable bit lives in the watchdog control register.

`timescale 1ns/1ps

module wsc_wake_cfg #(
   parameter logic [wsc_pkg::CNT_W-1:0] LONG_FILTER_CYCLES = wsc_pkg::LONG_FILTER_CYC
) (
   // Clock and reset
   input  wire logic                              i_clock,
   input  wire logic                              i_arst_n,
   // Serial configuration port
   input  wire wsc_pkg::wsc_spi_in_s              i_spi,
   output wsc_pkg::wsc_spi_out_s                  o_spi,
   // Wake pins and timer events
   input  wire logic [wsc_pkg::NUM_PINS-1:0]      i_wake_pin,
   input  wire logic                              i_first_timer_on_end,
   input  wire logic                              i_second_timer_on_end,
   input  wire logic                              i_first_timer_wake,
   input  wire logic                              i_second_timer_wake,
   // Device state and updates
   input  wire logic                              i_failsafe_entry,
   input  wire logic                              i_normal_mode,
   input  wire logic                              i_dog_upper_load,
   input  wire logic                              i_dog_upper_value,
   input  wire logic                              i_dog_stop_disable_lower,
   input  wire logic                              i_other_status_pending,
   input  wire logic [wsc_pkg::NUM_FLAGS-1:0]     i_wake_flag_clear,
   // Configuration and status
   output logic [1:0]                             o_timer_wake_enable,
   output logic [1:0]                             o_dog_stop_disable,
   output logic                                   o_measure_run,
   output logic [wsc_pkg::NUM_PINS-1:0]           o_pin_level,
   output logic [wsc_pkg::NUM_PINS-1:0]           o_pull_up,
   output logic [wsc_pkg::NUM_PINS-1:0]           o_pull_down,
   output logic [wsc_pkg::NUM_FLAGS-1:0]          o_wake_flags,
   output logic                                   o_interrupt
);

   localparam int NP = wsc_pkg::NUM_PINS;
   localparam int CW = wsc_pkg::CNT_W;

   // Long filter must not be shorter than the short one
   if (LONG_FILTER_CYCLES < wsc_pkg::SHORT_FILTER_CYC) begin : g_bad_long
      $error("LONG_FILTER_CYCLES shorter than the short filter");
   end

   // ************************************************************
   // Input synchronisers
   // ************************************************************
   logic [NP+2:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
   logic          csn_s, sclk_s, sdi_s;
   logic [NP-1:0] pin_s;

   // Two stages for every pin from outside
   always_comb begin
      sync1_next = {i_spi.csn_n, i_spi.sclk, i_spi.sdi, i_wake_pin};
      sync2_next = sync1_reg;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_reg <= {1'b1, {(NP+2){1'b0}}};
         sync2_reg <= {1'b1, {(NP+2){1'b0}}};
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   assign csn_s  = sync2_reg[NP+2];
   assign sclk_s = sync2_reg[NP+1];
   assign sdi_s  = sync2_reg[NP];
   assign pin_s  = sync2_reg[NP-1:0];

   // ************************************************************
   // Register storage and read decode
   // ************************************************************
   logic [7:0] tdw_reg, ext_reg, pull_reg, flt_reg;
   logic [7:0] tdw_next, ext_next, pull_next, flt_next;

   // Unmapped addresses read zero so a stray read cannot mislead
   function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] tdw,
                                           input logic [7:0] ext, input logic [7:0] pull,
                                           input logic [7:0] flt);
      logic [7:0] data;
      data = 8'h00;
      unique case (addr)
         wsc_pkg::ADDR_TIMER_DOG_WAKE: data = tdw;
         wsc_pkg::ADDR_EXT_WAKE:       data = ext;
         wsc_pkg::ADDR_PIN_PULL:       data = pull;
         wsc_pkg::ADDR_PIN_FILTER:     data = flt;
         default:                      data = 8'h00;
      endcase
      return data;
   endfunction : reg_read

   // ************************************************************
   // Serial slave: 7 address bits, write bit, 8 data bits, LSB first
   // ************************************************************
   logic        csn_d_reg, sclk_d_reg, sdo_reg, sdo_oe_reg;
   logic [4:0]  cnt_reg, cnt_next;
   logic [15:0] shin_reg, shin_next;
   logic [7:0]  shout_reg, shout_next;
   logic        sdo_next, sdo_oe_next, sclk_rise, sclk_fall, wr_en;

   // Shift in on rising, shift out on falling clock edge
   always_comb begin
      sclk_rise   = sclk_s & ~sclk_d_reg;
      sclk_fall   = ~sclk_s & sclk_d_reg;
      cnt_next    = cnt_reg;
      shin_next   = shin_reg;
      shout_next  = shout_reg;
      sdo_next    = sdo_reg;
      sdo_oe_next = ~csn_s;
      // Only a frame of exactly sixteen bits may write
      wr_en = csn_s & ~csn_d_reg & (cnt_reg == wsc_pkg::FRAME_BITS) & shin_reg[7];
      if (csn_s) begin
         cnt_next = 5'h00;
         sdo_next = 1'b0;
      end else begin
         if (sclk_rise) begin
            if (cnt_reg < wsc_pkg::FRAME_BITS) begin
               shin_next[cnt_reg[3:0]] = sdi_s;
               cnt_next = cnt_reg + 5'h01;
            end else begin
               cnt_next = wsc_pkg::FRAME_OVER;
            end
            if (cnt_reg == wsc_pkg::ADDR_BITS - 5'h01) begin
               shout_next = reg_read(shin_reg[6:0], tdw_reg, ext_reg, pull_reg, flt_reg);
            end
         end
         if (sclk_fall) begin
            if ((cnt_reg >= wsc_pkg::ADDR_BITS) && (cnt_reg < wsc_pkg::FRAME_BITS)) begin
               sdo_next = shout_reg[3'(cnt_reg - wsc_pkg::ADDR_BITS)];
            end else begin
               sdo_next = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         csn_d_reg  <= 1'b1;
         sclk_d_reg <= 1'b0;
         cnt_reg    <= 5'h00;
         shin_reg   <= 16'h0000;
         shout_reg  <= 8'h00;
         sdo_reg    <= 1'b0;
         sdo_oe_reg <= 1'b0;
      end else begin
         csn_d_reg  <= csn_s;
         sclk_d_reg <= sclk_s;
         cnt_reg    <= cnt_next;
         shin_reg   <= shin_next;
         shout_reg  <= shout_next;
         sdo_reg    <= sdo_next;
         sdo_oe_reg <= sdo_oe_next;
      end
   end

   assign o_spi.sdo    = sdo_reg;
   assign o_spi.sdo_oe = sdo_oe_reg;

   // ************************************************************
   // Register update: serial write, device update, fail-safe force
   // ************************************************************
   always_comb begin
      tdw_next  = tdw_reg;
      ext_next  = ext_reg;
      pull_next = pull_reg;
      flt_next  = flt_reg;
      if (wr_en) begin
         unique case (shin_reg[6:0])
            wsc_pkg::ADDR_TIMER_DOG_WAKE:
               tdw_next  = shin_reg[15:8] & wsc_pkg::MASK_TIMER_DOG_WAKE;
            wsc_pkg::ADDR_EXT_WAKE:
               ext_next  = shin_reg[15:8] & wsc_pkg::MASK_EXT_WAKE;
            wsc_pkg::ADDR_PIN_PULL:
               pull_next = shin_reg[15:8] & wsc_pkg::MASK_PIN_PULL;
            wsc_pkg::ADDR_PIN_FILTER:
               flt_next  = shin_reg[15:8] & wsc_pkg::MASK_PIN_FILTER;
            default: ;
         endcase
      end
      if (i_dog_upper_load) begin
         tdw_next[wsc_pkg::BIT_DOG_STOP_UPPER] = i_dog_upper_value;
      end
      if (i_failsafe_entry) begin
         ext_next = (ext_reg & wsc_pkg::FAILSAFE_KEEP_MASK) | wsc_pkg::FAILSAFE_EXT_WAKE;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tdw_reg  <= wsc_pkg::RST_TIMER_DOG_WAKE;
         ext_reg  <= wsc_pkg::RST_EXT_WAKE;
         pull_reg <= wsc_pkg::RST_PIN_PULL;
         flt_reg  <= wsc_pkg::RST_PIN_FILTER;
      end else begin
         tdw_reg  <= tdw_next;
         ext_reg  <= ext_next;
         pull_reg <= pull_next;
         flt_reg  <= flt_next;
      end
   end

   // ************************************************************
   // Wake pin filters, one per pin
   // ************************************************************
   logic [NP-1:0] pin_evt, lvl_reg, lvl_next, pin_enable;

   for (genvar p = 0; p < NP; p++) begin : g_pin
      logic [CW-1:0] cnt_reg_p, cnt_next_p, limit;
      logic          arm_reg, arm_next, go;
      logic [1:0]    mode;

      // Accept a level only after it stood for the whole filter time
      always_comb begin
         mode       = flt_reg[p*2 +: 2];
         limit      = (mode == wsc_pkg::FLT_STATIC_LONG) ? LONG_FILTER_CYCLES
                                                         : wsc_pkg::SHORT_FILTER_CYC;
         // cyclic window opened by on-time end
         go         = ~mode[1] | arm_reg |
                      (mode[0] ? i_second_timer_on_end : i_first_timer_on_end);
         cnt_next_p = {CW{1'b0}};
         arm_next   = 1'b0;
         lvl_next[p] = lvl_reg[p];
         pin_evt[p]  = 1'b0;
         if (go && (pin_s[p] != lvl_reg[p])) begin
            arm_next = mode[1];
            if (cnt_reg_p == limit - {{(CW-1){1'b0}}, 1'b1}) begin
               lvl_next[p] = pin_s[p];
               pin_evt[p]  = 1'b1;
               arm_next    = 1'b0;
            end else begin
               cnt_next_p = cnt_reg_p + {{(CW-1){1'b0}}, 1'b1};
            end
         end
      end

      always_ff @(posedge i_clock or negedge i_arst_n) begin
         if (!i_arst_n) begin
            cnt_reg_p <= {CW{1'b0}};
            arm_reg   <= 1'b0;
         end else begin
            cnt_reg_p <= cnt_next_p;
            arm_reg   <= arm_next;
         end
      end
   end

   assign pin_enable = {ext_reg[2],
                        ext_reg[1] & ~ext_reg[wsc_pkg::BIT_MEASURE_SELECT],
                        ext_reg[0] & ~ext_reg[wsc_pkg::BIT_MEASURE_SELECT]};

   // ************************************************************
   // Wake flags, interrupt and pin-facing outputs
   // ************************************************************
   logic [wsc_pkg::NUM_FLAGS-1:0] flag_reg, flag_next, flag_set;
   logic                          int_reg, int_next, meas_reg, meas_next;
   logic [1:0]                    lower_reg;
   logic [NP-1:0]                 pu_reg, pd_reg, pu_next, pd_next;

   // A set in the same cycle as its clear wins, so no wake is lost
   always_comb begin
      flag_set = {NP+2{1'b0}};
      flag_set[NP-1:0] = pin_evt & pin_enable;
      flag_set[wsc_pkg::FLAG_FIRST_TIMER] =
         i_first_timer_wake & tdw_reg[wsc_pkg::BIT_FIRST_TIMER_WAKE];
      flag_set[wsc_pkg::FLAG_SECOND_TIMER] =
         i_second_timer_wake & tdw_reg[wsc_pkg::BIT_SECOND_TIMER_WAKE];
      flag_next = (flag_reg & ~i_wake_flag_clear) | flag_set;
      // scope bit widens interrupt to all status
      int_next  = (|flag_next) |
                  (ext_reg[wsc_pkg::BIT_INT_GLOBAL] & i_other_status_pending);
      meas_next = ext_reg[wsc_pkg::BIT_MEASURE_SELECT] & i_normal_mode;
      pu_next   = {NP{1'b0}};
      pd_next   = {NP{1'b0}};
      for (int k = 0; k < NP; k++) begin
         // pull codes, auto follows accepted level
         unique case (pull_reg[k*2 +: 2])
            wsc_pkg::PULL_NONE: ;
            wsc_pkg::PULL_DOWN: pd_next[k] = 1'b1;
            wsc_pkg::PULL_UP:   pu_next[k] = 1'b1;
            wsc_pkg::PULL_AUTO: begin
               pu_next[k] = lvl_reg[k];
               pd_next[k] = ~lvl_reg[k];
            end
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_reg  <= {NP+2{1'b0}};
         int_reg   <= 1'b0;
         meas_reg  <= 1'b0;
         lower_reg <= 2'h0;
         lvl_reg   <= {NP{1'b0}};
         pu_reg    <= {NP{1'b0}};
         pd_reg    <= {NP{1'b0}};
      end else begin
         flag_reg  <= flag_next;
         int_reg   <= int_next;
         meas_reg  <= meas_next;
         // lower stop-mode bit arrives from the watchdog bank
         lower_reg <= {tdw_next[wsc_pkg::BIT_DOG_STOP_UPPER], i_dog_stop_disable_lower};
         lvl_reg   <= lvl_next;
         pu_reg    <= pu_next;
         pd_reg    <= pd_next;
      end
   end

   assign o_timer_wake_enable = {tdw_reg[wsc_pkg::BIT_SECOND_TIMER_WAKE],
                                 tdw_reg[wsc_pkg::BIT_FIRST_TIMER_WAKE]};
   assign o_dog_stop_disable  = lower_reg;
   assign o_measure_run       = meas_reg;
   assign o_pin_level         = lvl_reg;   // Meaningless for first and second pins while measuring
   assign o_pull_up           = pu_reg;
   assign o_pull_down         = pd_reg;
   assign o_wake_flags        = flag_reg;
   assign o_interrupt         = int_reg;

endmodule : wsc_wake_cfg

/* File: tb/wsc_wake_cfg_properties.sv */
/* Checker for wsc_wake_cfg: timer wake, flags, interrupt, pulls, filter.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module wsc_wake_cfg_chk #(
   parameter logic [wsc_pkg::CNT_W-1:0] LONG_FILTER_CYCLES = wsc_pkg::LONG_FILTER_CYC
) (
   // Clock, reset and causes
   input wire logic       i_clock,
   input wire logic       i_arst_n,
   input wire logic [2:0] i_wake_pin,
   input wire logic       i_first_timer_wake,
   input wire logic       i_second_timer_wake,
   input wire logic       i_dog_stop_disable_lower,
   input wire logic       i_other_status_pending,
   input wire logic [4:0] i_wake_flag_clear,
   // Observed outputs
   input wire logic [1:0] o_timer_wake_enable,
   input wire logic [1:0] o_dog_stop_disable,
   input wire logic [2:0] o_pin_level,
   input wire logic [2:0] o_pull_up,
   input wire logic [2:0] o_pull_down,
   input wire logic [4:0] o_wake_flags,
   input wire logic       o_interrupt
);
   // ******
   // Relations, all on the core clock
   // ******
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);
   t1_wake_a: assert property (i_first_timer_wake && o_timer_wake_enable[0] |=> o_wake_flags[3])
      else $error("first timer flag missing");
   t2_wake_a: assert property (i_second_timer_wake && o_timer_wake_enable[1] |=> o_wake_flags[4])
      else $error("second timer flag missing");
   t1_gate_a: assert property (!o_wake_flags[3] && !(i_first_timer_wake && o_timer_wake_enable[0])
      |=> !o_wake_flags[3]) else $error("first timer flag without cause");
   dog_lower_a: assert property ($past(i_arst_n) |->
      o_dog_stop_disable[0] == $past(i_dog_stop_disable_lower)) else $error("lower stop bit wrong");
   flag_hold_a: assert property (o_wake_flags[2] && !i_wake_flag_clear[2] |=> o_wake_flags[2])
      else $error("wake flag lost");
   irq_flag_a: assert property (o_wake_flags != 5'h00 |-> o_interrupt)
      else $error("interrupt missing for flag");
   irq_scope_a: assert property ($past(i_arst_n) && o_wake_flags == 5'h00
      && !$past(i_other_status_pending) |-> !o_interrupt) else $error("interrupt without cause");
   pull_excl_a: assert property ((o_pull_up & o_pull_down) == 3'h0)
      else $error("pull-up and pull-down together");
   lvl_filter_a: assert property ($rose(o_pin_level[2]) |-> $past(i_wake_pin[2], 8))
      else $error("level accepted without filtering");
endmodule : wsc_wake_cfg_chk

bind wsc_wake_cfg wsc_wake_cfg_chk #(.LONG_FILTER_CYCLES(LONG_FILTER_CYCLES)) wsc_wake_cfg_chk_i (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_wake_pin(i_wake_pin),
   .i_first_timer_wake(i_first_timer_wake), .i_second_timer_wake(i_second_timer_wake),
   .i_dog_stop_disable_lower(i_dog_stop_disable_lower),
   .i_other_status_pending(i_other_status_pending), .i_wake_flag_clear(i_wake_flag_clear),
   .o_timer_wake_enable(o_timer_wake_enable), .o_dog_stop_disable(o_dog_stop_disable),
   .o_pin_level(o_pin_level), .o_pull_up(o_pull_up), .o_pull_down(o_pull_down),
   .o_wake_flags(o_wake_flags), .o_interrupt(o_interrupt));

/* File: tb/wsc_host_model.sv */
/* Host model: sends 16-bit configuration frames, LSB first.
   Assumes the device samples after synced clock edges, so every half
   period lasts five core clocks. */
`timescale 1ns/1ps
module wsc_host_model (
   // Clock and returned data
   input  wire logic            i_clock,
   input  wire logic            i_sdo,
   // Serial pins towards the device
   output wsc_pkg::wsc_spi_in_s o_spi
);
   // ******
   // Frame engine
   // ******
   // Idle: deselected, clock low
   initial o_spi = 3'h4;
   // Changes land just after an edge
   task automatic gap(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : gap
   // bus wakes never set here
   // Address, direction, data; read data comes back in q
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
      logic [15:0] f;
      f = {d, w, a};
      q = 8'h00;
      gap(1);
      o_spi.csn_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         o_spi.sdi = f[i];
         gap(5);
         if (i > 7) q[i-8] = i_sdo;
         o_spi.sclk = 1'b1;
         gap(5);
         o_spi.sclk = 1'b0;
      end
      gap(5);
      o_spi.csn_n = 1'b1;
      // Released data line shows no stale value
      o_spi.sdi = ~o_spi.sdi;
      gap(8);
   endtask : xfer
endmodule : wsc_host_model

/* File: tb/wsc_wake_cfg_tb.sv */
/* Testbench for wsc_wake_cfg: registers, enables, filters and flags.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
module wsc_wake_cfg_tb;
   // ******
   // Signals
   // ******
   logic                  i_clock = 1'b0;
   logic                  i_arst_n = 1'b0;
   wsc_pkg::wsc_spi_in_s  spi_in;
   wsc_pkg::wsc_spi_out_s spi_out;
   logic [2:0]            pin = 3'h0;
   logic [1:0]            t_end = 2'h0;  // {second, first}
   logic [1:0]            t_wake = 2'h0; // {second, first}
   logic                  fs = 1'b0;
   logic                  dog_load = 1'b0;
   logic                  dog_lower = 1'b0;
   logic                  dog_val = 1'b0;
   logic                  nm = 1'b1;
   logic                  other = 1'b0;
   logic [4:0]            clr = 5'h00;
   logic [1:0]            twe;
   logic [1:0]            dog;
   logic                  meas;
   logic [2:0]            lvl;
   logic [2:0]            pu;
   logic [2:0]            pd;
   logic [4:0]            flags;
   logic                  irq;
   logic [7:0]            q;
   int                    num_errors = 0;
   int                    checks_done = 0;
   // 250 MHz clock
   always #2 i_clock = ~i_clock;
   // Long filter kept short to bound run time
   wsc_wake_cfg #(.LONG_FILTER_CYCLES(15'h1130)) wsc_wake_cfg_i (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_spi(spi_in), .o_spi(spi_out),
      .i_wake_pin(pin), .i_first_timer_on_end(t_end[0]), .i_second_timer_on_end(t_end[1]),
      .i_first_timer_wake(t_wake[0]), .i_second_timer_wake(t_wake[1]),
      .i_failsafe_entry(fs), .i_normal_mode(nm), .i_dog_upper_load(dog_load),
      .i_dog_upper_value(dog_val), .i_dog_stop_disable_lower(dog_lower),
      .i_other_status_pending(other), .i_wake_flag_clear(clr),
      .o_timer_wake_enable(twe), .o_dog_stop_disable(dog), .o_measure_run(meas),
      .o_pin_level(lvl), .o_pull_up(pu), .o_pull_down(pd), .o_wake_flags(flags),
      .o_interrupt(irq));
   wsc_host_model wsc_host_model_i (.i_clock(i_clock), .i_sdo(spi_out.sdo), .o_spi(spi_in));
   // ******
   // Tasks
   // ******
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      wsc_host_model_i.xfer(a, 1'b1, d, q);
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      wsc_host_model_i.xfer(a, 1'b0, 8'h00, q);
      chk(16'(q), 16'(e));
   endtask : rd
   // Flag must rise inside [lo, hi) cycles; a miss ends the run
   task automatic wflag(input int b, input int lo, input int hi);
      int n;
      n = 0;
      while (flags[b] !== 1'b1 && n < hi) begin
         tick(1);
         n++;
      end
      chk(16'(n >= lo && n < hi), 16'h1);
      if (n >= hi) print_verdict();
   endtask : wflag
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   // ******
   // Sequence
   // ******
   initial begin
      logic [7:0] rv [4] = '{8'h00, 8'h07, 8'h00, 8'h00};
      logic [7:0] mk [4] = '{8'hC4, 8'hA7, 8'h3F, 8'h3F};
      tick(12);
      i_arst_n = 1'b1;
      tick(4);
      for (int i = 0; i < 4; i++) begin
         rd(7'(6 + i), rv[i]);
         wr(7'(6 + i), 8'hFF);
         rd(7'(6 + i), mk[i]);
      end
      wr(7'h0A, 8'hFF);
      rd(7'h0A, 8'h00);
      chk(16'(spi_out.sdo_oe), 16'h0);
      chk(16'({twe, dog, meas}), 16'h1D);
      nm = 1'b0;
      tick(2);
      chk(16'(meas), 16'h0);
      nm = 1'b1;
      other = 1'b1;
      tick(2);
      chk(16'(irq), 16'h1);
      wr(7'h07, 8'h27);
      chk(16'(irq), 16'h0);
      other = 1'b0;
      dog_lower = 1'b1;
      dog_load = 1'b1;
      tick(1);
      dog_load = 1'b0;
      rd(7'h06, 8'hC0);
      chk(16'(dog), 16'h1);
      dog_val = 1'b1;
      dog_load = 1'b1;
      tick(1);
      dog_load = 1'b0;
      tick(1);
      chk(16'(dog), 16'h3);
      // Timer wakes enabled, then disabled
      for (int k = 0; k < 2; k++) begin
         t_wake = 2'h3;
         tick(1);
         t_wake = 2'h0;
         tick(1);
         chk(16'(flags), k ? 16'h00 : 16'h18);
         clr = 5'h1F;
         tick(1);
         clr = 5'h00;
         wr(7'h06, 8'h00);
      end
      wr(7'h07, 8'hA0);
      fs = 1'b1;
      tick(1);
      fs = 1'b0;
      rd(7'h07, 8'hA7);
      wr(7'h08, 8'h18);
      chk(16'({pu, pd}), 16'h14);
      wr(7'h08, 8'h24);
      chk(16'({pu, pd}), 16'h22);
      // Static short filter, measurement masks first pin
      wr(7'h07, 8'h27);
      wr(7'h09, 8'h00);
      pin = 3'h5;
      wflag(2, 3990, 4020);
      chk(16'({lvl, flags[0], irq}), 16'h15);
      wr(7'h08, 8'h3F);
      chk(16'({pu, pd}), 16'h2A);
      wr(7'h07, 8'h07);
      wr(7'h09, 8'h04);
      pin = 3'h7;
      wflag(1, 4390, 4420);
      // Cyclic sensing waits for on-time end
      pin = 3'h0;
      i_arst_n = 1'b0;
      tick(2);
      i_arst_n = 1'b1;
      tick(3);
      wr(7'h09, 8'h32);
      pin = 3'h5;
      tick(4100);
      chk(16'({flags[2], flags[0]}), 16'h0);
      t_end = 2'h1;
      tick(1);
      t_end = 2'h0;
      wflag(0, 3990, 4020);
      t_end = 2'h2;
      tick(1);
      t_end = 2'h0;
      wflag(2, 3990, 4020);
      print_verdict();
   end
endmodule : wsc_wake_cfg_tb
